// ---- logic/mhdf_pkg.sv ----
// Shared constants and types of the modem host data FIFOs.
// Assumes one clock for both ends and a byte-addressed 16-bit register port.
package mhdf_pkg;

  // Register offsets
  localparam logic [7:0]  A_CMD_DATA = 8'h48;  // Command data byte, pushes
  localparam logic [7:0]  A_CMD_CTRL = 8'h49;  // Command held control byte
  localparam logic [7:0]  A_CMD_WORD = 8'h4a;  // Command word, pushes
  localparam logic [7:0]  A_CMD_LVL  = 8'h4b;  // Command FIFO fill level
  localparam logic [7:0]  A_RX_DATA  = 8'h4c;  // Receive data byte, pops
  localparam logic [7:0]  A_RX_CTRL  = 8'h4d;  // Receive control byte, no pop
  localparam logic [7:0]  A_RX_WORD  = 8'h4e;  // Receive word, pops
  localparam logic [7:0]  A_RX_LVL   = 8'h4f;  // Receive FIFO fill level
  localparam logic [7:0]  A_FCTL     = 8'h50;  // FIFO control, write only
  localparam logic [7:0]  A_BUF_LVL  = 8'h70;  // Internal buffer levels

  // Depths and pointer widths
  localparam logic [3:0]  FQ_DEPTH   = 4'h8;   // Host-facing FIFO entries
  localparam logic [3:0]  BUF_DEPTH  = 4'h4;   // Internal buffer entries
  localparam int          FQ_AW      = 3;
  localparam int          BUF_AW     = 2;

  // FIFO control field positions
  localparam int          FC_FL_CMD  = 0;      // Flush command FIFO and buffer
  localparam int          FC_FL_RX   = 1;      // Flush receive FIFO and buffer
  localparam int          FC_IE_CMD  = 2;      // Command level interrupt enable
  localparam int          FC_IE_RX   = 3;      // Receive level interrupt enable
  localparam int          FC_IE_BLK  = 4;      // Block complete interrupt enable
  localparam int          FC_CTH_LO  = 8;      // Command threshold, 4 bits
  localparam int          FC_RTH_LO  = 12;     // Receive threshold, 4 bits

  // Buffer level register field positions
  localparam int          BL_CMD_LO  = 0;      // Command buffer level, 4 bits
  localparam int          BL_RX_LO   = 8;      // Receive buffer level, 4 bits
  localparam int          BL_BLK     = 15;     // Block complete flag

  // Control byte fields in raw mode
  localparam int          CTL_BLK    = 7;      // Item closes a block
  localparam logic [3:0]  BITS_FULL  = 4'h8;   // Bits in a whole byte

  // Framing patterns added around the payload
  localparam logic [7:0]  PREAMBLE   = 8'haa;
  localparam logic [7:0]  SYNC_PAT   = 8'h5a;
  localparam logic [7:0]  TAIL_PAT   = 8'h00;
  localparam logic [3:0]  TAIL_BITS  = 4'h8;

  // Transmit sequencer states
  typedef enum logic [2:0] {TX_IDLE, TX_PRE, TX_SYNC, TX_DATA, TX_TAIL} mhdf_tx_type;

  // Host end states
  typedef enum logic [0:0] {H_IDLE, H_WAIT} mhdf_host_type;

  // Valid bit count of a raw item; zero or out of range means a full byte
  function automatic logic [3:0] mhdf_nbits(input logic [7:0] ctl);
    return (ctl[3:0] == 4'h0 || ctl[3:0] > BITS_FULL) ? BITS_FULL : ctl[3:0];
  endfunction : mhdf_nbits

  // Fill count after an optional push and pop
  function automatic logic [3:0] mhdf_cnt(input logic [3:0] c, input logic inc, input logic dec);
    return c + {3'h0, inc} - {3'h0, dec};
  endfunction : mhdf_cnt

endpackage : mhdf_pkg

// ---- logic/mhdf_if.sv ----
// Register link between the host end and the modem end.
// Assumes both ends run on the same clock; one request in flight at a time.
`timescale 1ns/1ns
interface mhdf_if;
  logic        req;       // One-cycle access request
  logic        we;        // Write when high
  logic [7:0]  addr;      // Register offset
  logic [15:0] wdata;     // Write data
  logic        ack;       // One-cycle answer
  logic [15:0] rdata;     // Read data, valid with ack
  logic        irq;       // Interrupt level
  logic        raw_mode;  // Raw versus formatted selection
  logic        busy;      // Transmission in progress

  modport dev  (input req, we, addr, wdata, raw_mode, output ack, rdata, irq, busy);
  modport host (output req, we, addr, wdata, raw_mode, input ack, rdata, irq, busy);
endinterface : mhdf_if

// ---- logic/mhdf_dev.sv ----
// Modem end: command FIFO and buffer, receive buffer and FIFO, transmit framer.
// Assumes the core sends symbols without back-pressure and feeds received bits.
// Behaviour
// [RL1] Items are 16 bits, control over data
// [RL2] Word write enqueues and holds control byte
// [RL3] Data byte write enqueues held control byte
// [RL4] Control byte write only updates held byte
// [RL5] Control byte read leaves receive FIFO unchanged
// [RL6] Data byte read returns data and pops
// [RL7] Word read returns item and pops
// [RL8] Levels readable; FIFO control register writes
// [RL9] Threshold and block complete interrupts
// [RL10] Raw mode held for whole transmission
// [RL11] Preamble, sync and tail added internally
// [RL12] Carrier-sense fallback flushes command path
// [RL13] No other flush without host command
// [RL14] Internal buffers move data one item per cycle
// [RL15] Buffer levels readable; flushed with FIFO
// [RL16] Raw control byte ends block, interrupt
// [RL17] Raw items carry any bit count
// [RL18] Most significant bit first, left aligned
// [RL19] Bits grouped into symbols per modulation
// [RL20] Blockless streaming in both directions
// [RL21] Host sends largest blocks then remainder
// [RL22] Host sizes transfers from fill levels
`timescale 1ns/1ns
module mhdf_dev
  import mhdf_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  mhdf_if.dev             lk,
  input  wire logic       tx_en,         // Core is in transmit mode
  input  wire logic       cs_fallback,   // Carrier-sense attempt fell back to receive
  input  wire logic [2:0] mod_bits,      // Bits per symbol: 2, 4 or 6
  output logic            sym_valid,     // Symbol strobe
  output logic [5:0]      sym_data,      // Symbol, first bit in the top used position
  input  wire logic       rx_bit_valid,  // Received bit strobe
  input  wire logic       rx_bit,        // Received bit, first bit is most significant
  input  wire logic       rx_last,       // Closes a short final byte
  output logic            rx_bit_ready   // Receive buffer has room
);

  typedef struct packed {
    logic [7:0][15:0]  cq;       // Command FIFO
    logic [FQ_AW-1:0]  cq_wr;
    logic [FQ_AW-1:0]  cq_rd;
    logic [3:0]        cq_cnt;
    logic [3:0][15:0]  cb;       // Command buffer
    logic [BUF_AW-1:0] cb_wr;
    logic [BUF_AW-1:0] cb_rd;
    logic [3:0]        cb_cnt;
    logic [7:0][15:0]  rq;       // Receive FIFO
    logic [FQ_AW-1:0]  rq_wr;
    logic [FQ_AW-1:0]  rq_rd;
    logic [3:0]        rq_cnt;
    logic [3:0][15:0]  rb;       // Receive buffer
    logic [BUF_AW-1:0] rb_wr;
    logic [BUF_AW-1:0] rb_rd;
    logic [3:0]        rb_cnt;
    logic [7:0]        hold;     // Held command control byte
    logic [15:0]       fctl;     // FIFO control copy
    logic              blk_done; // Sticky block complete
    logic              ack;
    logic [15:0]       rdata;
    logic              irq;
    mhdf_tx_type       tst;      // Transmit sequencer
    logic [7:0]        tsh;      // Outgoing bit shifter
    logic [3:0]        tleft;    // Bits left in shifter
    logic              tblk;     // Current item closes a block
    logic              tmode;    // Mode latched at start
    logic [2:0]        tbps;     // Bits per symbol latched at start
    logic [5:0]        sym;      // Symbol being assembled
    logic [2:0]        scnt;
    logic              sym_v;
    logic [5:0]        sym_o;
    logic [7:0]        rsh;      // Incoming bit shifter
    logic [3:0]        rcnt;
  } mhdf_dev_state_type;

  mhdf_dev_state_type s_ff;      // Registered state
  mhdf_dev_state_type nxt_s;     // Next state

  logic        cq_push, cq_pop, cb_push, cb_pop;  // Command path moves
  logic        rq_push, rq_pop, rb_push, rb_pop;  // Receive path moves
  logic        fl_cmd, fl_rx;                     // Flush requests
  logic [15:0] cq_din, rb_din, cb_head, rq_head;
  logic        tbit_v;                            // A bit leaves this cycle
  logic [7:0]  rbyte;
  logic [3:0]  rk;

  assign cb_head = s_ff.cb[s_ff.cb_rd];
  assign rq_head = s_ff.rq[s_ff.rq_rd];

  // Ports straight from flops except busy, decoded from the sequencer state; ready is a handshake term
  assign lk.ack       = s_ff.ack;
  assign lk.rdata     = s_ff.rdata;
  assign lk.irq       = s_ff.irq;
  assign lk.busy      = (s_ff.tst != TX_IDLE);
  assign sym_valid    = s_ff.sym_v;
  assign sym_data     = s_ff.sym_o;
  // [RL14] Receive buffer gates bits
  assign rx_bit_ready = (s_ff.rb_cnt != BUF_DEPTH);

  // All next-state logic
  always_comb
  begin
    nxt_s   = s_ff;
    nxt_s.ack   = 1'b0;
    nxt_s.sym_v = 1'b0;
    cq_push = 1'b0;
    cq_pop  = 1'b0;
    cb_push = 1'b0;
    cb_pop  = 1'b0;
    rq_push = 1'b0;
    rq_pop  = 1'b0;
    rb_push = 1'b0;
    rb_pop  = 1'b0;
    fl_cmd  = 1'b0;
    fl_rx   = 1'b0;
    cq_din  = 16'h0000;
    rb_din  = 16'h0000;
    tbit_v  = 1'b0;
    rbyte   = 8'h00;
    rk      = 4'h0;

    // Register access, one cycle to the answer
    if (lk.req)
    begin
      nxt_s.ack   = 1'b1;
      nxt_s.rdata = 16'h0000;
      if (lk.we)
      begin
        unique case (lk.addr)
          // [RL3] Held control plus byte
          A_CMD_DATA:
          begin
            cq_push = (s_ff.cq_cnt != FQ_DEPTH);
            cq_din  = {s_ff.hold, lk.wdata[7:0]};
          end
          // [RL4] No enqueue here
          A_CMD_CTRL: nxt_s.hold = lk.wdata[7:0];
          // [RL2] Whole word enqueued
          A_CMD_WORD:
          begin
            nxt_s.hold = lk.wdata[15:8];
            cq_push    = (s_ff.cq_cnt != FQ_DEPTH);
            cq_din     = lk.wdata;
          end
          // [RL8] FIFO control write
          A_FCTL:
          begin
            nxt_s.fctl = lk.wdata;
            // [RL13] Host-ordered flushes
            fl_cmd     = lk.wdata[FC_FL_CMD];
            fl_rx      = lk.wdata[FC_FL_RX];
          end
          // Unmapped or read-only: write ignored
          default: ;
        endcase
      end
      else
      begin
        unique case (lk.addr)
          // [RL8] Fill levels
          A_CMD_LVL: nxt_s.rdata = {12'h000, s_ff.cq_cnt};
          A_RX_LVL:  nxt_s.rdata = {12'h000, s_ff.rq_cnt};
          // [RL5] Peek only
          A_RX_CTRL: nxt_s.rdata = (s_ff.rq_cnt != 4'h0) ? {8'h00, rq_head[15:8]} : 16'h0000;
          // [RL6] Data byte and pop
          A_RX_DATA:
          begin
            nxt_s.rdata = (s_ff.rq_cnt != 4'h0) ? {8'h00, rq_head[7:0]} : 16'h0000;
            rq_pop      = (s_ff.rq_cnt != 4'h0);
          end
          // [RL7] Whole item and pop
          A_RX_WORD:
          begin
            nxt_s.rdata = (s_ff.rq_cnt != 4'h0) ? rq_head : 16'h0000;
            rq_pop      = (s_ff.rq_cnt != 4'h0);
          end
          // [RL15] Buffer levels; reading clears the block flag
          A_BUF_LVL:
          begin
            nxt_s.rdata = '0;
            nxt_s.rdata[BL_CMD_LO +: 4] = s_ff.cb_cnt;
            nxt_s.rdata[BL_RX_LO +: 4]  = s_ff.rb_cnt;
            nxt_s.rdata[BL_BLK]         = s_ff.blk_done;
            nxt_s.blk_done              = 1'b0;
          end
          // Unmapped or write-only reads as zero
          default: ;
        endcase
      end
    end

    // [RL14] One item per cycle, command FIFO to buffer, receive buffer to FIFO
    cb_push = (s_ff.cq_cnt != 4'h0) && (s_ff.cb_cnt != BUF_DEPTH);
    cq_pop  = cb_push;
    rq_push = (s_ff.rb_cnt != 4'h0) && (s_ff.rq_cnt != FQ_DEPTH);
    rb_pop  = rq_push;

    // [RL18] Receive shifter, first bit on top
    if (rx_bit_valid && rx_bit_ready)
    begin
      rk         = s_ff.rcnt + 4'h1;
      nxt_s.rsh  = {s_ff.rsh[6:0], rx_bit};
      nxt_s.rcnt = rk;
      // [RL17] Short final byte kept left aligned
      if (rk == BITS_FULL || rx_last)
      begin
        rbyte      = nxt_s.rsh << (BITS_FULL - rk);
        // [RL1] Control holds bit count
        rb_din     = {4'h0, rk, rbyte};
        rb_push    = 1'b1;
        nxt_s.rcnt = 4'h0;
      end
    end

    // Transmit sequencer: a shifter empty cycle loads the next segment
    if (s_ff.tleft != 4'h0)
    begin
      tbit_v      = 1'b1;
      nxt_s.tsh   = {s_ff.tsh[6:0], 1'b0};
      nxt_s.tleft = s_ff.tleft - 4'h1;
    end
    else
    begin
      unique case (s_ff.tst)
        TX_IDLE:
          if (tx_en && s_ff.cb_cnt != 4'h0)
          begin
            // [RL10] Mode frozen for the transmission
            nxt_s.tmode = lk.raw_mode;
            nxt_s.tbps  = mod_bits;
            // [RL11] Preamble first
            nxt_s.tst   = TX_PRE;
            nxt_s.tsh   = PREAMBLE;
            nxt_s.tleft = BITS_FULL;
          end
        TX_PRE:
        begin
          // [RL11] Then frame sync
          nxt_s.tst   = TX_SYNC;
          nxt_s.tsh   = SYNC_PAT;
          nxt_s.tleft = BITS_FULL;
        end
        TX_SYNC:
        begin
          nxt_s.tst  = TX_DATA;
          nxt_s.tblk = 1'b0;
        end
        TX_DATA:
        begin
          // [RL16] Block sent in full
          if (s_ff.tblk)
            nxt_s.blk_done = 1'b1;
          nxt_s.tblk = 1'b0;
          // [RL20] Streams while items keep arriving
          if (s_ff.cb_cnt != 4'h0)
          begin
            cb_pop      = 1'b1;
            nxt_s.tsh   = cb_head[7:0];
            // [RL17] Raw items may carry fewer bits
            nxt_s.tleft = s_ff.tmode ? mhdf_nbits(cb_head[15:8]) : BITS_FULL;
            nxt_s.tblk  = s_ff.tmode & cb_head[8 + CTL_BLK];
          end
          else
          begin
            // [RL11] Tail closes the burst
            nxt_s.tst   = TX_TAIL;
            nxt_s.tsh   = TAIL_PAT;
            nxt_s.tleft = TAIL_BITS;
          end
        end
        TX_TAIL:
        begin
          // Partial symbol padded with zeros so no bit is stranded
          if (s_ff.scnt != 3'h0)
          begin
            nxt_s.sym_v = 1'b1;
            nxt_s.sym_o = s_ff.sym << (s_ff.tbps - s_ff.scnt);
            nxt_s.scnt  = 3'h0;
            nxt_s.sym   = 6'h00;
          end
          nxt_s.tst = TX_IDLE;
        end
      endcase
    end

    // [RL19] Symbol assembly per modulation
    if (tbit_v)
    begin
      // [RL18] Top bit leaves first
      nxt_s.sym  = {s_ff.sym[4:0], s_ff.tsh[7]};
      nxt_s.scnt = s_ff.scnt + 3'h1;
      if (nxt_s.scnt == s_ff.tbps)
      begin
        nxt_s.sym_v = 1'b1;
        nxt_s.sym_o = nxt_s.sym;
        nxt_s.scnt  = 3'h0;
        nxt_s.sym   = 6'h00;
      end
    end

    // Queue storage and pointers
    if (cq_push)
    begin
      nxt_s.cq[s_ff.cq_wr] = cq_din;
      nxt_s.cq_wr = s_ff.cq_wr + 3'h1;
    end
    if (cq_pop)
      nxt_s.cq_rd = s_ff.cq_rd + 3'h1;
    if (cb_push)
    begin
      nxt_s.cb[s_ff.cb_wr] = s_ff.cq[s_ff.cq_rd];
      nxt_s.cb_wr = s_ff.cb_wr + 2'h1;
    end
    if (cb_pop)
      nxt_s.cb_rd = s_ff.cb_rd + 2'h1;
    if (rb_push)
    begin
      nxt_s.rb[s_ff.rb_wr] = rb_din;
      nxt_s.rb_wr = s_ff.rb_wr + 2'h1;
    end
    if (rb_pop)
      nxt_s.rb_rd = s_ff.rb_rd + 2'h1;
    if (rq_push)
    begin
      nxt_s.rq[s_ff.rq_wr] = s_ff.rb[s_ff.rb_rd];
      nxt_s.rq_wr = s_ff.rq_wr + 3'h1;
    end
    if (rq_pop)
      nxt_s.rq_rd = s_ff.rq_rd + 3'h1;
    nxt_s.cq_cnt = mhdf_cnt(s_ff.cq_cnt, cq_push, cq_pop);
    nxt_s.cb_cnt = mhdf_cnt(s_ff.cb_cnt, cb_push, cb_pop);
    nxt_s.rq_cnt = mhdf_cnt(s_ff.rq_cnt, rq_push, rq_pop);
    nxt_s.rb_cnt = mhdf_cnt(s_ff.rb_cnt, rb_push, rb_pop);

    // [RL12] Fallback empties command path and stops the sequencer
    if (fl_cmd || cs_fallback)
    begin
      // [RL15] Buffer emptied with its FIFO
      nxt_s.cq_wr  = '0;
      nxt_s.cq_rd  = '0;
      nxt_s.cq_cnt = 4'h0;
      nxt_s.cb_wr  = '0;
      nxt_s.cb_rd  = '0;
      nxt_s.cb_cnt = 4'h0;
      nxt_s.tst    = TX_IDLE;
      nxt_s.tleft  = 4'h0;
      nxt_s.tblk   = 1'b0;
      nxt_s.scnt   = 3'h0;
    end
    if (fl_rx)
    begin
      // [RL15] Receive side flush, partial byte too
      nxt_s.rq_wr  = '0;
      nxt_s.rq_rd  = '0;
      nxt_s.rq_cnt = 4'h0;
      nxt_s.rb_wr  = '0;
      nxt_s.rb_rd  = '0;
      nxt_s.rb_cnt = 4'h0;
      nxt_s.rcnt   = 4'h0;
    end

    // [RL9] Interrupt from levels and block flag
    nxt_s.irq = (nxt_s.fctl[FC_IE_CMD] && nxt_s.cq_cnt <= nxt_s.fctl[FC_CTH_LO +: 4])
             || (nxt_s.fctl[FC_IE_RX] && nxt_s.rq_cnt >= nxt_s.fctl[FC_RTH_LO +: 4]
                 && nxt_s.rq_cnt != 4'h0)
             || (nxt_s.fctl[FC_IE_BLK] && nxt_s.blk_done);
  end

  // State register, synchronous reset
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end

endmodule : mhdf_dev

// ---- logic/mhdf_host.sv ----
// Host end: turns user register requests into single link accesses.
// Assumes the modem end answers every request with one ack.
`timescale 1ns/1ns
module mhdf_host
  import mhdf_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  mhdf_if.host             lk,
  input  wire logic        u_valid,     // User request
  input  wire logic        u_we,        // Write when high
  input  wire logic [7:0]  u_addr,      // Register offset
  input  wire logic [15:0] u_wdata,     // Write data
  output logic             u_ready,     // Request taken this cycle
  output logic             u_rvalid,    // Answer strobe
  output logic [15:0]      u_rdata,     // Read data with the strobe
  input  wire logic        u_raw_mode,  // Wanted mode
  output logic             u_irq,       // Interrupt from the modem
  output logic             u_busy       // Transmission in progress
);

  typedef struct packed {
    mhdf_host_type st;
    logic          req;
    logic          we;
    logic [7:0]    addr;
    logic [15:0]   wdata;
    logic          raw;
    logic          rv;
    logic [15:0]   rd;
  } mhdf_host_state_type;

  mhdf_host_state_type s_ff;   // Registered state
  mhdf_host_state_type nxt_s;  // Next state

  assign lk.req      = s_ff.req;
  assign lk.we       = s_ff.we;
  assign lk.addr     = s_ff.addr;
  assign lk.wdata    = s_ff.wdata;
  assign lk.raw_mode = s_ff.raw;
  assign u_ready     = (s_ff.st == H_IDLE);
  assign u_rvalid    = s_ff.rv;
  assign u_rdata     = s_ff.rd;
  assign u_irq       = lk.irq;
  assign u_busy      = lk.busy;

  // One request in flight; the user paces streams on levels and interrupts
  always_comb
  begin
    nxt_s     = s_ff;
    nxt_s.req = 1'b0;
    nxt_s.rv  = 1'b0;
    // [RL10] Mode changes only between transmissions
    if (!lk.busy)
      nxt_s.raw = u_raw_mode;
    unique case (s_ff.st)
      H_IDLE:
        // [RL20] Streaming is back-to-back single accesses
        if (u_valid)
        begin
          nxt_s.req   = 1'b1;
          nxt_s.we    = u_we;
          nxt_s.addr  = u_addr;
          nxt_s.wdata = u_wdata;
          nxt_s.st    = H_WAIT;
        end
      H_WAIT:
        if (lk.ack)
        begin
          nxt_s.rv = 1'b1;
          nxt_s.rd = lk.rdata;
          nxt_s.st = H_IDLE;
        end
    endcase
  end

  // State register, synchronous reset
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end

endmodule : mhdf_host

// ---- dv/mhdf_properties.sv ----
// Link checker for the modem host data FIFOs.
// Assumes one clock; sits beside the link that joins both ends.
`timescale 1ns/1ns
module mhdf_properties
  import mhdf_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic        req,
  input wire logic        we,
  input wire logic [7:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        ack,
  input wire logic [15:0] rdata,
  input wire logic        irq,
  input wire logic        raw_mode,
  input wire logic        busy
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Read request on the link
  wire rd = req && !we;
  ack_after_req_a: assert property (req |=> ack)
    else $error("ack missing after request");
  ack_has_cause_a: assert property (ack |-> $past(req))
    else $error("ack without request");
  host_spacing_a: assert property (req |=> !req [*2])
    else $error("requests too close");
  write_no_data_a: assert property (req && we |=> rdata == 16'h0000)
    else $error("write returned data");
  ctl_wo_read_a: assert property (rd && addr == A_FCTL |=> rdata == 16'h0000)
    else $error("fifo control readable");
  cmd_lvl_max_a: assert property (rd && addr == A_CMD_LVL |=> rdata <= {12'h000, FQ_DEPTH})
    else $error("command level too large");
  buf_lvl_max_a: assert property (rd && addr == A_BUF_LVL |=>
    rdata[3:0] <= BUF_DEPTH && rdata[11:8] <= BUF_DEPTH) else $error("buffer level too large");
  mode_held_a: assert property (busy |-> $stable(raw_mode))
    else $error("mode changed in transmission");
  unmapped_zero_a: assert property (rd && addr == 8'h60 |=> rdata == 16'h0000)
    else $error("unmapped read not zero");
endmodule : mhdf_properties

// ---- dv/modem_host_data_fifos_bench.sv ----
// Bench for the modem host data FIFOs, both ends joined by the link.
// Assumes the host end serialises accesses; one clock, symbols of two then four bits.
`timescale 1ns/1ns
module modem_host_data_fifos_bench import mhdf_pkg::*;;
  logic        clk_sys      = 1'b0;
  logic        rstn         = 1'b0;
  logic        u_valid      = 1'b0;
  logic        u_we         = 1'b0;
  logic [7:0]  u_addr       = 8'h00;
  logic [15:0] u_wdata      = 16'h0000;
  logic        u_raw_mode   = 1'b0;
  logic        tx_en        = 1'b0;
  logic        cs_fallback  = 1'b0;
  logic        rx_bit_valid = 1'b0;
  logic        rx_bit       = 1'b0;
  logic        rx_last      = 1'b0;
  logic [2:0]  mod_bits     = 3'h2;   // Bits per symbol, two then four
  logic        u_ready, u_rvalid, u_irq, u_busy, sym_valid, rx_bit_ready;
  logic [15:0] u_rdata, rv;
  logic [5:0]  sym_data;
  logic [35:0] tx_bits      = '0;     // Sent bits, oldest highest
  int          n_sym        = 0;
  int          mismatches   = 0;
  int          n_compared   = 0;
  mhdf_if lk ();
  mhdf_dev i_mhdf_dev (.clk_sys, .rstn, .lk, .tx_en, .cs_fallback, .mod_bits, .sym_valid,
    .sym_data, .rx_bit_valid, .rx_bit, .rx_last, .rx_bit_ready);
  mhdf_host i_mhdf_host (.clk_sys, .rstn, .lk, .u_valid, .u_we, .u_addr, .u_wdata, .u_ready,
    .u_rvalid, .u_rdata, .u_raw_mode, .u_irq, .u_busy);
  mhdf_properties i_mhdf_properties (.clk_sys, .rstn, .req(lk.req), .we(lk.we), .addr(lk.addr),
    .wdata(lk.wdata), .ack(lk.ack), .rdata(lk.rdata), .irq(lk.irq), .raw_mode(lk.raw_mode),
    .busy(lk.busy));
  initial forever #5 clk_sys = ~clk_sys;
  // Symbol collector; a shift register keeps the last 36 bits
  always @(posedge clk_sys)
  begin
    if (sym_valid === 1'b1)
    begin
      // Four-bit symbols take the low nibble, two-bit ones the low pair
      if (mod_bits == 3'h4)
        tx_bits <= {tx_bits[31:0], sym_data[3:0]};
      else
        tx_bits <= {tx_bits[33:0], sym_data[1:0]};
      n_sym   <= n_sym + 1;
    end
  end
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  // Hang guard, well above the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    report_and_stop();
  end
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // One register access; request held until taken, answer caught on its strobe
  task automatic acc(input logic we, input logic [7:0] a, input logic [15:0] d);
    int n;
    u_valid <= 1'b1;
    u_we    <= we;
    u_addr  <= a;
    u_wdata <= d;
    n = 0;
    @(posedge clk_sys);
    while (u_ready !== 1'b1 && n < 20)
    begin
      @(posedge clk_sys);
      n++;
    end
    u_valid <= 1'b0;
    @(posedge clk_sys);
    while (u_rvalid !== 1'b1 && n < 40)
    begin
      @(posedge clk_sys);
      n++;
    end
    rv = u_rdata;
    if (n >= 40)
      mismatches++;
  endtask : acc
  task automatic rdc(input string what, input logic [7:0] a, input logic [15:0] e,
                     input logic [15:0] m = 16'hffff);
    acc(1'b0, a, 16'h0000);
    chk(what, rv & m, e);
  endtask : rdc
  // Received bits, first bit the most significant; short bytes close with rx_last
  task automatic rx_send(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++)
    begin
      rx_bit_valid <= 1'b1;
      rx_bit       <= b[7 - i];
      rx_last      <= (i == n - 1) && (n < 8);
      @(posedge clk_sys);
    end
    rx_bit_valid <= 1'b0;
    rx_last      <= 1'b0;
    repeat (8) @(posedge clk_sys);
  endtask : rx_send
  // One transmission to its end; a hang counts as a mismatch
  task automatic tx_run();
    int n;
    tx_en <= 1'b1;
    n = 0;
    while (u_busy !== 1'b1 && n < 20)
    begin
      @(posedge clk_sys);
      n++;
    end
    // Mode request flips mid-burst; the host end must hold it
    u_raw_mode <= ~u_raw_mode;
    while (u_busy === 1'b1 && n < 300)
    begin
      @(posedge clk_sys);
      n++;
    end
    tx_en <= 1'b0;
    if (n >= 300)
      mismatches++;
    repeat (4) @(posedge clk_sys);
  endtask : tx_run
  initial
  begin
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    rdc("cmd level", A_CMD_LVL, 16'h0000);
    rdc("buf level", A_BUF_LVL, 16'h0000);
    rdc("unmapped", 8'h60, 16'h0000);
    u_raw_mode <= 1'b1;
    acc(1'b1, A_CMD_CTRL, 16'h0012);
    rdc("ctrl only", A_BUF_LVL, 16'h0000);
    // Twelve fit in buffer and FIFO, the thirteenth is dropped
    for (int i = 0; i < 13; i++)
      acc(1'b1, A_CMD_WORD, 16'h0100 + 16'(i));
    rdc("cmd full", A_CMD_LVL, 16'h0008);
    rdc("buf full", A_BUF_LVL, 16'h0004);
    cs_fallback <= 1'b1;
    @(posedge clk_sys);
    cs_fallback <= 1'b0;
    rdc("fallback cmd", A_CMD_LVL, 16'h0000);
    rdc("fallback buf", A_BUF_LVL, 16'h0000);
    // Raw burst: a 5-bit block, then 3-bit remainders by word and held control
    acc(1'b1, A_FCTL, 16'h0010);
    rdc("fctl reads 0", A_FCTL, 16'h0000);
    acc(1'b1, A_CMD_CTRL, 16'h0085);
    acc(1'b1, A_CMD_DATA, 16'h00b0);
    acc(1'b1, A_CMD_WORD, 16'h03e0);
    acc(1'b1, A_CMD_DATA, 16'h00c0);
    tx_run();
    chk("framing", tx_bits[35:20], {PREAMBLE, SYNC_PAT});
    chk("payload", tx_bits[19:4], {5'h16, 3'h7, 3'h6, 5'h00});
    chk("tail pad", {12'h000, tx_bits[3:0]}, 16'h0000);
    chk("symbols", 16'(n_sym), 16'd18);
    chk("block irq", {15'h0000, u_irq}, 16'h0001);
    rdc("block flag", A_BUF_LVL, 16'h8000, 16'h8000);
    chk("irq cleared", {15'h0000, u_irq}, 16'h0000);
    // Host end took the flipped mode once idle: formatted, four-bit symbols
    mod_bits <= 3'h4;
    acc(1'b1, A_CMD_WORD, 16'h0385);
    tx_run();
    chk("fmt framing", tx_bits[31:16], {PREAMBLE, SYNC_PAT});
    chk("fmt payload", tx_bits[15:0], {8'h85, TAIL_PAT});
    chk("fmt symbols", 16'(n_sym), 16'h001a);
    rdc("fmt no block", A_BUF_LVL, 16'h0000, 16'h8000);
    // Receive a full byte and a three-bit tail
    acc(1'b1, A_FCTL, 16'h1008);
    chk("rx ready", {15'h0000, rx_bit_ready}, 16'h0001);
    rx_send(8'hc5, 8);
    rx_send(8'ha0, 3);
    chk("rx irq", {15'h0000, u_irq}, 16'h0001);
    acc(1'b1, A_FCTL, 16'h1009);
    // Reads sized from the receive level
    rdc("rx level", A_RX_LVL, 16'h0002);
    rdc("rx ctrl", A_RX_CTRL, 16'h0008, 16'h00ff);
    rdc("rx kept", A_RX_LVL, 16'h0002);
    rdc("rx data", A_RX_DATA, 16'h00c5, 16'h00ff);
    rdc("next ctrl", A_RX_CTRL, 16'h0003, 16'h00ff);
    rdc("rx word", A_RX_WORD, 16'h03a0);
    rdc("rx empty", A_RX_DATA, 16'h0000);
    chk("rx irq off", {15'h0000, u_irq}, 16'h0000);
    rx_send(8'hff, 8);
    acc(1'b1, A_FCTL, 16'h0002);
    rdc("rx flushed", A_RX_LVL, 16'h0000);
    rdc("bufs flushed", A_BUF_LVL, 16'h0000);
    report_and_stop();
  end
endmodule : modem_host_data_fifos_bench
